/* i2c_reg_consts.svh */
// constants for the i2c register-access controller
`ifndef I2C_REG_CONSTS_SVH
`define I2C_REG_CONSTS_SVH
`define CLK_HZ            200000000
`define RATE_100K_HZ      100000
`define RATE_250K_HZ      250000
`define RATE_400K_HZ      400000
`define RECOVERY_US       500
`define RECOVERY_CYCLES   ((`RECOVERY_US * (`CLK_HZ / 1000000)))
`define CFG_NO_RECOVERY   0
`define RW_WRITE          1'b0
`define RW_READ           1'b1
`define STATUS_OK         2'h0
`define STATUS_NACK       2'h1
`define STATUS_BAD_RATE   2'h2
`define STATUS_NOT_OPEN   2'h3
`endif

/* i2c_reg_pkg.sv */
// types for the i2c register-access controller
package i2c_reg_pkg;
  typedef enum logic [3:0] {
    ST_CLOSED  = 4'b0000,
    ST_RECOVER = 4'b0001,
    ST_IDLE    = 4'b0010,
    ST_START   = 4'b0011,
    ST_BYTE    = 4'b0100,
    ST_ACK     = 4'b0101,
    ST_RSTART  = 4'b0110,
    ST_STOP    = 4'b0111,
    ST_DONE    = 4'b1000
  } ctl_state_e;
  typedef enum logic [1:0] {
    BIT_START = 2'b00,
    BIT_DATA  = 2'b01,
    BIT_STOP  = 2'b10,
    BIT_RSTRT = 2'b11
  } bit_kind_e;
endpackage

/* bit_link_if.sv */
// request/answer link between the byte sequencer and the bit engine
interface bit_link_if;
  import i2c_reg_pkg::*;
  logic      req;
  bit_kind_e kind;
  logic      sda_out;
  logic      done;
  logic      sda_in;
  modport seq (output req, output kind, output sda_out,
               input done, input sda_in);
  modport eng (input req, input kind, input sda_out,
               output done, output sda_in);
endinterface

/* i2c_bit_engine.sv */
// one i2c bit, start, stop or repeated start as four quarter phases
module i2c_bit_engine
  import i2c_reg_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [15:0] quarter_in,
  input  wire logic        sda_pin_in,
  output logic             scl_oe_out,
  output logic             sda_oe_out,
  bit_link_if.eng          lnk
);
  logic [15:0] cnt_r;
  logic [1:0]  ph_r;
  logic        busy_r;
  logic [2:0]  sync_r;
  logic        sda_q_r;
  logic        tick;
  logic        scl_low;
  logic        sda_low;

  // sda changes count once the second and third stages agree
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sync_r  <= 3'h7;
      sda_q_r <= 1'b1;
    end else begin
      sync_r <= {sync_r[1:0], sda_pin_in};
      if (sync_r[1] == sync_r[2])
        sda_q_r <= sync_r[2];
    end
  end

  assign tick = busy_r && (cnt_r == quarter_in);

  // line levels per phase; oe high pulls the wire low
  always_comb begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    case (lnk.kind)
      BIT_START: begin
        scl_low = (ph_r == 2'h3);
        sda_low = (ph_r >= 2'h2);
      end
      BIT_RSTRT: begin
        scl_low = (ph_r == 2'h0) || (ph_r == 2'h3);
        sda_low = (ph_r >= 2'h2);
      end
      BIT_STOP: begin
        scl_low = (ph_r == 2'h0);
        sda_low = (ph_r <= 2'h2);
      end
      default: begin
        scl_low = (ph_r == 2'h0) || (ph_r == 2'h3);
        sda_low = !lnk.sda_out;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_r      <= 16'h0000;
      ph_r       <= 2'h0;
      busy_r     <= 1'b0;
      lnk.done   <= 1'b0;
      lnk.sda_in <= 1'b1;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      lnk.done <= 1'b0;
      if (!busy_r && lnk.req && !lnk.done) begin
        busy_r <= 1'b1;
        ph_r   <= 2'h0;
        cnt_r  <= 16'h0000;
      end else if (tick) begin
        cnt_r <= 16'h0000;
        // sample data at the end of scl high, as phase 2 ends
        if (ph_r == 2'h2)
          lnk.sda_in <= sda_q_r;
        if (ph_r == 2'h3) begin
          busy_r   <= 1'b0;
          lnk.done <= 1'b1;
        end
        ph_r <= ph_r + 2'h1;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 16'h0001;
      end
      scl_oe_out <= busy_r ? scl_low : scl_oe_out;
      sda_oe_out <= busy_r ? sda_low : sda_oe_out;
    end
  end
endmodule

/* i2c_reg_master.sv */
// single-master i2c controller doing 8-bit register writes and reads
// Summary of operation
// - clock rate 100k, 250k or 400k only
// - 500 us low recovery pulse unless bit0
// - close releases bus; repeated close harmless
// - seven-bit target address per access
// - eight-bit register index sent each access
// - byte write stores one data byte
// - only low eight data bits transmitted
// - byte read returns one byte to host
// - sole master, no arbitration logic
// - master always drives scl; sda shared
`include "i2c_reg_consts.svh"
module i2c_reg_master
  import i2c_reg_pkg::*;
#(
  parameter int CLK_HZ     = `CLK_HZ,
  parameter int REC_CYCLES = `RECOVERY_CYCLES
)(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        open_request_in,
  input  wire logic [31:0] clock_rate_select_in,
  input  wire logic [31:0] config_flags_in,
  input  wire logic        close_request_in,
  input  wire logic        byte_write_op_in,
  input  wire logic        byte_read_op_in,
  input  wire logic [6:0]  target_address_in,
  input  wire logic [7:0]  register_index_in,
  input  wire logic [31:0] register_value_in,
  input  wire logic        sda_in,
  output logic             scl_out,
  output logic             scl_oe_out,
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic             is_open_out,
  output logic             busy_out,
  output logic             done_out,
  output logic [1:0]       status_out,
  output logic [7:0]       register_value_out
);
  initial begin
    if (CLK_HZ < 4 * `RATE_400K_HZ || REC_CYCLES < 1)
      $error("clock too slow for 400 kHz or bad recovery count");
  end

  bit_link_if lnk();
  ctl_state_e st_r;
  logic [15:0] quarter_r;
  logic [31:0] rec_r;
  logic        rd_r;
  logic [6:0]  addr_r;
  logic [7:0]  idx_r;
  logic [7:0]  data_r;
  logic [7:0]  sh_r;
  logic [2:0]  bit_r;
  logic [1:0]  byte_r;
  logic        phase_rd_r;
  logic        req_r;
  bit_kind_e   kind_r;
  logic        sdo_r;
  logic        rate_ok;
  logic [15:0] rate_q;
  logic        op_go;
  logic        last_byte;
  logic        eng_scl_oe;
  logic        eng_sda_oe;
  logic        rec_hold_r;
  logic [1:0]  res_status_r;
  logic [7:0]  res_data_r;

  function automatic logic [15:0] quarter_of(input logic [31:0] hz);
    quarter_of = 16'((CLK_HZ / 4) / hz - 1);
  endfunction

  // rate table
  assign rate_ok = (clock_rate_select_in == `RATE_100K_HZ) ||
                   (clock_rate_select_in == `RATE_250K_HZ) ||
                   (clock_rate_select_in == `RATE_400K_HZ);
  assign rate_q  = rate_ok ? quarter_of(clock_rate_select_in) : 16'h0000;
  assign op_go   = byte_write_op_in || byte_read_op_in;
  // read: byte 3 is the data-in byte; write: byte 2 is data
  assign last_byte = rd_r ? (byte_r == 2'h3) : (byte_r == 2'h2);

  assign lnk.req     = req_r;
  assign lnk.kind    = kind_r;
  assign lnk.sda_out = sdo_r;

  i2c_bit_engine u_eng (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .quarter_in (quarter_r),
    .sda_pin_in (sda_in),
    .scl_oe_out (eng_scl_oe),
    .sda_oe_out (eng_sda_oe),
    .lnk        (lnk)
  );

  // open drain: output is always low, oe pulls the line
  always_ff @(posedge clk_in) begin
    scl_out <= 1'b0;
    sda_out <= 1'b0;
  end

  // recovery holds both lines low until the stop bit takes over
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rec_hold_r <= 1'b0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      if (st_r == ST_RECOVER)
        rec_hold_r <= 1'b1;
      else if (st_r == ST_STOP && eng_scl_oe)
        rec_hold_r <= 1'b0;
      // handover needs no gap, or the lines would glitch high
      scl_oe_out <= eng_scl_oe || rec_hold_r;
      sda_oe_out <= eng_sda_oe || rec_hold_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_r <= ST_CLOSED; quarter_r <= 16'h0000; rec_r <= 32'h0;
      rd_r <= 1'b0; addr_r <= 7'h00; idx_r <= 8'h00; data_r <= 8'h00;
      sh_r <= 8'h00; bit_r <= 3'h0; byte_r <= 2'h0; phase_rd_r <= 1'b0;
      req_r <= 1'b0; kind_r <= BIT_DATA; sdo_r <= 1'b1;
      is_open_out <= 1'b0; busy_out <= 1'b0; done_out <= 1'b0;
      status_out <= `STATUS_OK; register_value_out <= 8'h00;
      res_status_r <= `STATUS_OK; res_data_r <= 8'h00;
    end else begin
      done_out <= 1'b0;
      if (lnk.done)
        req_r <= 1'b0;
      case (st_r)
        ST_CLOSED: begin
          if (open_request_in) begin
            done_out <= 1'b1;
            if (!rate_ok) begin
              status_out <= `STATUS_BAD_RATE;
            end else begin
              quarter_r   <= rate_q;
              is_open_out <= 1'b1;
              if (!config_flags_in[`CFG_NO_RECOVERY]) begin
                rec_r <= 32'(REC_CYCLES);
                res_status_r <= `STATUS_OK;
                busy_out <= 1'b1;
                done_out <= 1'b0;
                st_r <= ST_RECOVER;
              end else begin
                status_out <= `STATUS_OK;
                st_r <= ST_IDLE;
              end
            end
          end else if (op_go) begin
            done_out   <= 1'b1;
            status_out <= `STATUS_NOT_OPEN;
          end
          // close when closed
          // a close here needs no action and touches no line
        end
        ST_RECOVER: begin
          if (rec_r != 32'h0) begin
            rec_r <= rec_r - 32'h1;
            if (rec_r == 32'h1) begin
              kind_r <= BIT_STOP;
              req_r  <= 1'b1;
              st_r   <= ST_STOP;
            end
          end
        end
        ST_IDLE: begin
          if (close_request_in) begin
            is_open_out <= 1'b0;
            st_r <= ST_CLOSED;
          end else if (op_go) begin
            rd_r   <= byte_read_op_in;
            addr_r <= target_address_in;
            idx_r  <= register_index_in;
            data_r <= register_value_in[7:0];
            busy_out <= 1'b1;
            byte_r <= 2'h0;
            phase_rd_r <= 1'b0;
            kind_r <= BIT_START;
            req_r  <= 1'b1;
            st_r   <= ST_START;
          end
        end
        ST_START, ST_RSTART: begin
          if (lnk.done) begin
            sh_r   <= {addr_r, phase_rd_r ? `RW_READ : `RW_WRITE};
            bit_r  <= 3'h7;
            kind_r <= BIT_DATA;
            sdo_r  <= phase_rd_r ? addr_r[6] : addr_r[6];
            req_r  <= 1'b1;
            st_r   <= ST_BYTE;
          end else if (!req_r) begin
            req_r <= 1'b1;
          end
        end
        ST_BYTE: begin
          if (lnk.done) begin
            sh_r <= {sh_r[6:0], lnk.sda_in};
            if (bit_r == 3'h0) begin
              // master acks nothing: nack after the read byte
              sdo_r <= (byte_r == 2'h3) ? 1'b1 : 1'b1;
              req_r <= 1'b1;
              st_r  <= ST_ACK;
            end else begin
              bit_r <= bit_r - 3'h1;
              sdo_r <= (byte_r == 2'h3) ? 1'b1 : sh_r[6];
              req_r <= 1'b1;
            end
          end else if (!req_r && bit_r == 3'h7) begin
            sdo_r <= (byte_r == 2'h3) ? 1'b1 : sh_r[7];
            req_r <= 1'b1;
          end
        end
        ST_ACK: begin
          if (lnk.done) begin
            if (byte_r != 2'h3 && lnk.sda_in) begin
              res_status_r <= `STATUS_NACK;
              kind_r <= BIT_STOP;
              req_r  <= 1'b1;
              st_r   <= ST_STOP;
            end else if (last_byte) begin
              if (rd_r)
                res_data_r <= sh_r;
              res_status_r <= `STATUS_OK;
              kind_r <= BIT_STOP;
              req_r  <= 1'b1;
              st_r   <= ST_STOP;
            end else if (rd_r && byte_r == 2'h1) begin
              phase_rd_r <= 1'b1;
              byte_r <= 2'h2;
              kind_r <= BIT_RSTRT;
              req_r  <= 1'b1;
              st_r   <= ST_RSTART;
            end else begin
              byte_r <= byte_r + 2'h1;
              sh_r   <= (byte_r == 2'h0) ? idx_r :
                        (rd_r ? 8'hff : data_r);
              bit_r  <= 3'h7;
              kind_r <= BIT_DATA;
              st_r   <= ST_BYTE;
            end
          end
        end
        ST_STOP: begin
          if (lnk.done)
            st_r <= ST_DONE;
        end
        ST_DONE: begin
          // results change only together with the answer pulse
          busy_out <= 1'b0;
          done_out <= 1'b1;
          status_out <= res_status_r;
          register_value_out <= res_data_r;
          st_r <= ST_IDLE;
        end
        default: st_r <= ST_CLOSED;
      endcase
    end
  end
endmodule

/* i2c_reg_master_chk.sv */
// concurrent checks on the i2c register-access controller ports
`include "i2c_reg_consts.svh"
module i2c_reg_master_chk #(
  parameter int REC_CYCLES = 20
)(
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        open_request_in,
  input wire logic [31:0] clock_rate_select_in,
  input wire logic [31:0] config_flags_in,
  input wire logic        close_request_in,
  input wire logic        byte_write_op_in,
  input wire logic        byte_read_op_in,
  input wire logic        scl_out,
  input wire logic        scl_oe_out,
  input wire logic        sda_out,
  input wire logic        sda_oe_out,
  input wire logic        is_open_out,
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic [1:0]  status_out,
  input wire logic [7:0]  register_value_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic        free_w, op_w, rate_ok_w;
  logic [31:0] run_r, peak_r;
  logic        pend_r, rec_r;
  assign free_w = !busy_out;
  assign op_w = (byte_write_op_in || byte_read_op_in) && free_w;
  assign rate_ok_w = clock_rate_select_in inside
    {`RATE_100K_HZ, `RATE_250K_HZ, `RATE_400K_HZ};
  // longest stretch with both lines pulled low since the open request
  always_ff @(posedge clk_in) begin
    if (reset_in || open_request_in) begin
      run_r <= '0;
      peak_r <= '0;
    end else begin
      run_r <= (scl_oe_out && sda_oe_out) ? run_r + 1 : '0;
      peak_r <= (run_r > peak_r) ? run_r : peak_r;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in || done_out) begin
      pend_r <= 1'b0;
      rec_r <= 1'b0;
    end else if (open_request_in && free_w && !is_open_out) begin
      pend_r <= 1'b1;
      rec_r <= !config_flags_in[0];
    end
  end
  pins_low_a: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  idle_free_a: assert property (free_w |-> !scl_oe_out && !sda_oe_out)
    else $error("line held while not busy");
  done_pulse_a: assert property (done_out |=> !done_out)
    else $error("answer longer than one cycle");
  bad_rate_a: assert property (open_request_in && free_w &&
    !is_open_out && !rate_ok_w |-> ##[1:4]
    (done_out && status_out == `STATUS_BAD_RATE && !is_open_out))
    else $error("bad rate accepted");
  closed_op_a: assert property (op_w && !is_open_out |->
    ##[1:4] (done_out && status_out == `STATUS_NOT_OPEN))
    else $error("op while closed not refused");
  close_shut_a: assert property (close_request_in && free_w &&
    is_open_out |=> !is_open_out)
    else $error("close ignored");
  rec_pulse_a: assert property (done_out && pend_r && rec_r &&
    status_out == `STATUS_OK |-> peak_r >= REC_CYCLES)
    else $error("recovery pulse too short");
  skip_pulse_a: assert property (done_out && pend_r && !rec_r |->
    peak_r == 0)
    else $error("recovery pulse not skipped");
  op_busy_a: assert property (op_w && is_open_out |=> busy_out[*8])
    else $error("op not started");
  result_hold_a: assert property (!done_out |-> $stable(status_out) &&
    $stable(register_value_out))
    else $error("result changed without answer");
  cover property (done_out && status_out == `STATUS_NACK);
  cover property (done_out && pend_r && rec_r && status_out == `STATUS_OK);
  cover property (op_w && byte_read_op_in && is_open_out);
endmodule
bind i2c_reg_master i2c_reg_master_chk #(.REC_CYCLES(REC_CYCLES)) i_chk (
  .clk_in(clk_in), .reset_in(reset_in), .open_request_in(open_request_in),
  .clock_rate_select_in(clock_rate_select_in),
  .config_flags_in(config_flags_in), .close_request_in(close_request_in),
  .byte_write_op_in(byte_write_op_in), .byte_read_op_in(byte_read_op_in),
  .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .is_open_out(is_open_out),
  .busy_out(busy_out), .done_out(done_out), .status_out(status_out),
  .register_value_out(register_value_out));

/* i2c_slave_model.sv */
// behavioural i2c slave with a 256-byte register file
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h52
)(
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];
  logic [7:0] sh, idx;
  logic       act, rd, talk, hit;
  int         pos, phase;
  initial begin
    sda_oe_out = 1'b0;
    act = 1'b0;
    talk = 1'b0;
    hit = 1'b0;
    pos = 0;
  end
  // start or repeated start restarts framing
  always @(negedge sda_in) if (scl_in) begin
    act = 1'b1;
    pos = 0;
    phase = 0;
    talk = 1'b0;
    sda_oe_out = 1'b0;
  end
  always @(posedge sda_in) if (scl_in) act = 1'b0;
  always @(posedge scl_in) if (act) begin
    if (pos < 8) sh = {sh[6:0], sda_in};
    pos = (pos == 8) ? 0 : pos + 1;
  end
  always @(negedge scl_in) if (act) begin
    if (pos == 8 && !talk) begin
      // address match, then index, then stored data
      if (phase == 0) begin
        hit = sh[7:1] == ADDR;
        rd = sh[0];
      end else if (phase == 1) idx = sh;
      else mem[idx] = sh;
      sda_oe_out = hit;
      phase = phase + 1;
    end else if (pos == 0) begin
      // read data goes out msb first after the address ack
      talk = hit && rd && phase == 1;
      sda_oe_out = talk && !mem[idx][7];
    end else if (talk && pos < 8) sda_oe_out = !mem[idx][7-pos];
    else if (talk) begin
      sda_oe_out = 1'b0;
      talk = 1'b0;
      phase = 2;
    end
  end
endmodule

/* testbench.sv */
// self-checking bench for the i2c register-access controller
`include "i2c_reg_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] SLV = 7'h52;
  logic        clk_in, reset_in, opn, cls, wr, rd, s_oe, sda_w, scl_w;
  logic [31:0] rate, flags, val, rv;
  logic [6:0]  addr;
  logic [7:0]  idx, rx;
  logic        scl_out, scl_oe_out, sda_out, sda_oe_out;
  logic        is_open_out, busy_out, done_out;
  logic [1:0]  status_out;
  logic [7:0]  register_value_out;
  int          failures, checked, seed, i, j;
  i2c_reg_master #(.CLK_HZ(4000000), .REC_CYCLES(20)) i_dut (
    .clk_in(clk_in), .reset_in(reset_in), .open_request_in(opn),
    .clock_rate_select_in(rate), .config_flags_in(flags),
    .close_request_in(cls), .byte_write_op_in(wr), .byte_read_op_in(rd),
    .target_address_in(addr), .register_index_in(idx),
    .register_value_in(val), .sda_in(sda_w), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .is_open_out(is_open_out), .busy_out(busy_out), .done_out(done_out),
    .status_out(status_out), .register_value_out(register_value_out));
  // pull-ups on both lines, so a released line reads high
  assign scl_w = !scl_oe_out;
  assign sda_w = !(sda_oe_out || s_oe);
  i2c_slave_model #(.ADDR(SLV)) i_slave (
    .scl_in(scl_w), .sda_in(sda_w), .sda_oe_out(s_oe));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = !clk_in;
  end
  function automatic logic [7:0] low_byte(input logic [31:0] v);
    return v[7:0];
  endfunction
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (!ok) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // one request pulse {open, close, write, read}, then wait for the answer
  task automatic go(input logic [3:0] k, input logic [6:0] a,
                    input logic [7:0] x, input logic [31:0] v);
    int n;
    @(posedge clk_in) #1;
    {opn, cls, wr, rd} = k;
    addr = a;
    idx = x;
    val = v;
    @(posedge clk_in) #1;
    {opn, cls, wr, rd} = 4'h0;
    n = 0;
    while (done_out !== 1'b1 && n < ((k == 4'b0100) ? 8 : 4000)) begin
      @(posedge clk_in) #1;
      n++;
    end
    if (k != 4'b0100) chk(done_out === 1'b1, "no answer");
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk_in);
    failures++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    complete_run;
  end
  initial begin
    seed = 36642;
    {opn, cls, wr, rd} = 4'h0;
    reset_in = 1'b1;
    {rate, flags, val, addr, idx} = '0;
    failures = 0;
    checked = 0;
    repeat (6) @(posedge clk_in);
    #1 reset_in = 1'b0;
    go(4'b0010, SLV, 8'h00, 32'h0);
    chk(status_out === `STATUS_NOT_OPEN, "op while closed");
    rate = 32'd123456;
    go(4'b1000, 7'h00, 8'h00, 32'h0);
    chk(status_out === `STATUS_BAD_RATE && !is_open_out, "bad rate");
    $display("test refusals done");
    for (i = 0; i < 3; i++) begin
      rate = (i == 0) ? `RATE_100K_HZ : (i == 1) ? `RATE_250K_HZ
             : `RATE_400K_HZ;
      flags = {31'h0, i[0]};
      go(4'b1000, 7'h00, 8'h00, 32'h0);
      chk(status_out === `STATUS_OK && is_open_out, "open");
      for (j = 0; j < 3; j++) begin
        rv = (j == 0) ? 32'hffffff00 : $random(seed);
        rx = (j == 0) ? 8'hff : 8'($random(seed));
        go(4'b0010, SLV, rx, rv);
        chk(status_out === `STATUS_OK, "write");
        go(4'b0001, SLV, rx, 32'h0);
        chk(status_out === `STATUS_OK, "read");
        chk(register_value_out === low_byte(rv), "read back");
      end
      go(4'b0010, SLV ^ 7'h01, rx, rv);
      chk(status_out === `STATUS_NACK, "nack write");
      go(4'b0001, SLV ^ 7'h01, rx, 32'h0);
      chk(status_out === `STATUS_NACK, "nack read");
      go(4'b0100, 7'h00, 8'h00, 32'h0);
      go(4'b0100, 7'h00, 8'h00, 32'h0);
      chk(!is_open_out && !busy_out && !scl_oe_out, "close twice");
      $display("test rate %0d done", rate);
    end
    go(4'b1000, 7'h00, 8'h00, 32'h0);
    reset_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1 reset_in = 1'b0;
    chk(is_open_out === 1'b0 && status_out === `STATUS_OK, "reset");
    $display("test reset done");
    complete_run;
  end
endmodule
